//--- inc/nfc_pkg.sv
/*
 * Shared constants for the flash host controller: command bytes, pin
 * timing counts and the busy limits. Assumes a 50 MHz system clock.
 */
package nfc_pkg;

	localparam int CLK_NS = 20;

	// pin timing, least times round up to whole cycles
	localparam int T_SETUP_NS  = 12;
	localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_WP_NS     = 12;
	localparam int WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_WH_NS     = 10;
	localparam int HOLD_CYC    = (T_WH_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_WHR_NS    = 60;
	localparam int WHR_CYC     = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_REA_NS    = 20;
	localparam int RD_LOW_CYC  = (T_REA_NS + CLK_NS - 1) / CLK_NS + 1;
	// read strobe stays high this long, so the device is in normal mode
	localparam int T_READ_STROBE_HIGH_TIME_NS = 40;
	localparam int RD_TAIL_CYC = (T_READ_STROBE_HIGH_TIME_NS + CLK_NS - 1)
		/ CLK_NS;
	localparam int T_WB_NS     = 100;
	localparam int WB_CYC      = (T_WB_NS + CLK_NS - 1) / CLK_NS;

	// busy limits, longest times round down
	localparam int T_ARRAY_LOAD_US          = 25;
	localparam int T_CACHE_WRITE_BUSY_SHORT_US = 10;
	localparam int T_CACHE_WRITE_BUSY_LONG_US  = 700;
	localparam int T_CACHE_READ_BUSY_US     = 25;
	localparam int T_COPY_READ_BUSY_US      = 30;
	localparam int T_PROG_US                = 700;
	localparam int T_ERASE_US               = 5000;
	localparam int T_RST_RDY_US             = 5;
	localparam int T_RST_RD_US              = 5;
	localparam int T_RST_PROG_US            = 10;
	localparam int T_RST_ERASE_US           = 500;
	localparam int ARRAY_LOAD_CYC  = T_ARRAY_LOAD_US * 1000 / CLK_NS;
	localparam int CW_SHORT_CYC    = T_CACHE_WRITE_BUSY_SHORT_US * 1000 / CLK_NS;
	localparam int CACHE_RD_CYC    = T_CACHE_READ_BUSY_US * 1000 / CLK_NS;
	localparam int COPY_RD_CYC     = T_COPY_READ_BUSY_US * 1000 / CLK_NS;
	localparam int RST_RDY_CYC     = T_RST_RDY_US * 1000 / CLK_NS;
	localparam int RST_RD_CYC      = T_RST_RD_US * 1000 / CLK_NS;
	localparam int RST_PROG_CYC    = T_RST_PROG_US * 1000 / CLK_NS;

	localparam int TMR_W = 18;
	localparam logic [2:0] PP_MAX = 3'h4;
	localparam int STATUS_READY_BIT = 6;
	localparam int ROW_FIRST = 2;
	localparam int ROW_BYTES = 3;

	localparam logic [7:0] CMD_READ_GO       = 8'h30;
	localparam logic [7:0] CMD_CACHE_RD      = 8'h31;
	localparam logic [7:0] CMD_CACHE_RD_LAST = 8'h3F;
	localparam logic [7:0] CMD_COPY_RD       = 8'h3A;
	localparam logic [7:0] CMD_PROG          = 8'h10;
	localparam logic [7:0] CMD_MP_CONF       = 8'h11;
	localparam logic [7:0] CMD_CACHE_PROG    = 8'h15;
	localparam logic [7:0] CMD_ERASE_GO      = 8'hD0;
	localparam logic [7:0] CMD_STATUS        = 8'h70;
	localparam logic [7:0] CMD_STATUS_MP     = 8'h71;
	localparam logic [7:0] CMD_RESET         = 8'hFF;
	localparam logic [7:0] CMD_LOAD          = 8'h80;
	localparam logic [7:0] CMD_MP_LOAD       = 8'h81;
	localparam logic [7:0] CMD_COL_IN        = 8'h85;
	localparam logic [7:0] CMD_COPY_LOAD     = 8'h8C;

	typedef enum logic [1:0] {
		K_CMD   = 2'h0,
		K_ADDR  = 2'h1,
		K_WDATA = 2'h2,
		K_RDATA = 2'h3
	} nfc_kind_e;

	typedef enum logic [1:0] {
		CLS_NONE  = 2'h0,
		CLS_READ  = 2'h1,
		CLS_PROG  = 2'h2,
		CLS_ERASE = 2'h3
	} nfc_cls_e;

endpackage

//--- rtl/nfc_cycle.sv
/*
 * One bus cycle on the flash pins: a strobed write of a command, address
 * or data byte, or a strobed read of one byte. Assumes start_i is only
 * raised while no cycle runs and the data pins are resolved outside.
 */
`timescale 1ns/1ps
`default_nettype none
module nfc_cycle
	import nfc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       start_i,
	input  wire logic       rd_i,
	input  wire logic       cmd_i,
	input  wire logic       adr_i,
	input  wire logic [7:0] byte_i,
	output logic            done_o,
	output logic [7:0]      rdata_o,
	output logic            cmd_latch_o,
	output logic            addr_latch_o,
	output logic            write_strobe_n_o,
	output logic            read_strobe_n_o,
	output logic [7:0]      dq_o,
	output logic            dq_oe_o,
	input  wire logic [7:0] dq_i
);

	typedef enum logic [2:0] {
		C_IDLE  = 3'h0,
		C_SETUP = 3'h1,
		C_WLOW  = 3'h2,
		C_HOLD  = 3'h3,
		C_GAP   = 3'h4,
		C_RLOW  = 3'h5,
		C_TAIL  = 3'h6
	} nfc_cyc_e;

	nfc_cyc_e   state;
	nfc_cyc_e   next_state;
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic [7:0] dq_m;
	logic [7:0] dq_s;

	wire last  = cnt == 3'h0;
	wire begin_w = state == C_IDLE && start_i;
	wire drive = next_state == C_SETUP || next_state == C_WLOW
		|| next_state == C_HOLD;

	always_comb begin
		next_state = state;
		next_cnt = cnt - 3'h1;
		case (state)
			C_IDLE: begin
				next_cnt = cnt;
				if (start_i && rd_i) begin
					next_state = C_GAP;
					next_cnt = 3'(WHR_CYC - 1);
				end else if (start_i) begin
					next_state = C_SETUP;
					next_cnt = 3'(SETUP_CYC - 1);
				end
			end
			C_SETUP: if (last) begin
				next_state = C_WLOW;
				next_cnt = 3'(WP_CYC - 1);
			end
			C_WLOW: if (last) begin
				next_state = C_HOLD;
				next_cnt = 3'(HOLD_CYC - 1);
			end
			C_GAP: if (last) begin
				next_state = C_RLOW;
				next_cnt = 3'(RD_LOW_CYC - 1);
			end
			C_RLOW: if (last) begin
				next_state = C_TAIL;
				next_cnt = 3'(RD_TAIL_CYC - 1);
			end
			C_HOLD, C_TAIL: if (last) begin
				next_state = C_IDLE;
			end
			default: next_state = C_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= C_IDLE;
			cnt <= 3'h0;
			write_strobe_n_o <= 1'b1;
			read_strobe_n_o <= 1'b1;
			dq_oe_o <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			write_strobe_n_o <= next_state != C_WLOW;
			read_strobe_n_o <= next_state != C_RLOW;
			dq_oe_o <= drive;
		end
	end

	// latch selects stay up through the hold phase after the strobe rises
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_latch_o <= 1'b0;
			addr_latch_o <= 1'b0;
			dq_o <= 8'h00;
		end else if (begin_w) begin
			cmd_latch_o <= cmd_i && !rd_i;
			addr_latch_o <= adr_i && !rd_i;
			dq_o <= byte_i;
		end else if (next_state == C_IDLE) begin
			cmd_latch_o <= 1'b0;
			addr_latch_o <= 1'b0;
		end
	end

	// read data comes through two flops; the byte kept is the one sampled on
	// the edge that raises the strobe, before the device releases the pins
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dq_m <= 8'h00;
			dq_s <= 8'h00;
			rdata_o <= 8'h00;
			done_o <= 1'b0;
		end else begin
			dq_m <= dq_i;
			dq_s <= dq_m;
			done_o <= (state == C_HOLD || state == C_TAIL) && last;
			if (state == C_TAIL && last)
				rdata_o <= dq_s;
		end
	end

endmodule
`default_nettype wire

//--- rtl/nfc_host.sv
/*
 * Flash host controller: takes byte requests from user logic, plays them
 * on the flash pins, waits out and times each busy period, guards partial
 * programs and closes an open cache program before any command other than a program, load, status or reset.
 * Assumes a pull-up on the ready/busy wire and one flash device.
 */
`timescale 1ns/1ps
`default_nettype none
module nfc_host
	import nfc_pkg::*;
#(
	parameter int PROG_MAX_CYC  = T_PROG_US * 1000 / CLK_NS,
	parameter int ERASE_MAX_CYC = T_ERASE_US * 1000 / CLK_NS,
	parameter int RST_ERASE_CYC = T_RST_ERASE_US * 1000 / CLK_NS
)(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       req_valid_i,
	output logic            req_ready_o,
	input  wire logic [1:0] req_kind_i,
	input  wire logic [7:0] req_byte_i,
	output logic            rsp_valid_o,
	output logic [7:0]      rsp_byte_o,
	output logic            ctl_busy_o,
	output logic            fail_o,
	output logic            pp_err_o,
	output logic            chip_sel_n_o,
	output logic            write_prot_n_o,
	output logic            cmd_latch_o,
	output logic            addr_latch_o,
	output logic            write_strobe_n_o,
	output logic            read_strobe_n_o,
	output logic [7:0]      dq_o,
	output logic            dq_oe_o,
	input  wire logic [7:0] dq_i,
	input  wire logic       ready_busy_out_i
);

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_CYC  = 3'h1,
		S_WB   = 3'h2,
		S_BUSY = 3'h3,
		S_FCMD = 3'h4,
		S_FRD  = 3'h5,
		S_FRST = 3'h6
	} nfc_st_e;

	nfc_st_e          state;
	nfc_st_e          next_state;
	nfc_kind_e        cur_kind;
	nfc_cls_e         cls;
	nfc_cls_e         op_cls;
	logic [7:0]       cur_byte;
	logic             cyc_busy;
	logic             cyc_done;
	logic [7:0]       cyc_rdata;
	logic [2:0]       wbc;
	logic [TMR_W-1:0] tmr;
	logic [TMR_W-1:0] lim;
	logic [TMR_W-1:0] ld_val;
	logic             busy_start;
	logic             need_fin;
	logic [2:0]       addr_idx;
	logic [7:0]       row [ROW_BYTES];
	logic [7:0]       last_row [ROW_BYTES];
	logic [2:0]       pp_cnt;
	logic             rb_m;
	logic             rb_s;

	wire is_cmd = req_kind_i == K_CMD;
	wire fin_ok = req_byte_i == CMD_LOAD || req_byte_i == CMD_MP_LOAD
		|| req_byte_i == CMD_COL_IN || req_byte_i == CMD_COPY_LOAD
		|| req_byte_i == CMD_PROG || req_byte_i == CMD_MP_CONF
		|| req_byte_i == CMD_CACHE_PROG || req_byte_i == CMD_STATUS
		|| req_byte_i == CMD_STATUS_MP || req_byte_i == CMD_RESET;
	wire fin_trig = need_fin && is_cmd && !fin_ok;
	// only a reset may cut into a busy period
	wire abort_ok = state == S_BUSY && is_cmd && req_byte_i == CMD_RESET;
	assign req_ready_o = (state == S_IDLE && !fin_trig) || abort_ok;
	wire take = req_valid_i && req_ready_o;
	wire pconf = is_cmd && (req_byte_i == CMD_PROG
		|| req_byte_i == CMD_MP_CONF || req_byte_i == CMD_CACHE_PROG);
	wire same_row = row == last_row;
	wire pp_full = same_row && pp_cnt == PP_MAX;
	wire drop = take && pconf && pp_full;
	wire op_done = state == S_CYC && cyc_done;
	wire cur_cmd = cur_kind == K_CMD;
	wire stat_rdy = cyc_done && cyc_rdata[STATUS_READY_BIT];
	wire ld_fin = state == S_IDLE && req_valid_i && fin_trig;
	wire ld_op = op_done && busy_start;
	wire ld_rst = state == S_FRST && cyc_done;
	wire tmo_busy = state == S_BUSY && !rb_s && tmr == '0 && !take;
	wire tmo_fin = state == S_FRD && tmr == '0 && !stat_rdy;
	wire cyc_start = !cyc_busy && (state == S_CYC || state == S_FCMD
		|| state == S_FRD || state == S_FRST);
	wire cyc_rd = state == S_FRD || (state == S_CYC && cur_kind == K_RDATA);
	wire cyc_cmd = state != S_CYC || cur_cmd;
	wire cyc_adr = state == S_CYC && cur_kind == K_ADDR;
	wire [7:0] cyc_byte = state == S_FCMD ? CMD_STATUS
		: state == S_FRST ? CMD_RESET : cur_byte;
	assign ctl_busy_o = state != S_IDLE;

	// busy limit and class of the command just strobed
	always_comb begin
		busy_start = cur_cmd;
		op_cls = CLS_NONE;
		lim = TMR_W'(RST_RDY_CYC);
		case (cur_byte)
			CMD_READ_GO: begin
				lim = TMR_W'(ARRAY_LOAD_CYC);
				op_cls = CLS_READ;
			end
			CMD_CACHE_RD, CMD_CACHE_RD_LAST: begin
				lim = TMR_W'(CACHE_RD_CYC);
				op_cls = CLS_READ;
			end
			CMD_COPY_RD: begin
				lim = TMR_W'(COPY_RD_CYC);
				op_cls = CLS_READ;
			end
			CMD_MP_CONF: begin
				lim = TMR_W'(CW_SHORT_CYC);
				op_cls = CLS_PROG;
			end
			CMD_CACHE_PROG: begin
				lim = TMR_W'(PROG_MAX_CYC);
				op_cls = CLS_PROG;
			end
			CMD_PROG: begin
				// a cache tail may need its own and the previous page's time
				lim = need_fin ? TMR_W'(2 * PROG_MAX_CYC)
					: TMR_W'(PROG_MAX_CYC);
				op_cls = CLS_PROG;
			end
			CMD_ERASE_GO: begin
				lim = TMR_W'(ERASE_MAX_CYC);
				op_cls = CLS_ERASE;
			end
			CMD_RESET: begin
				case (cls)
					CLS_ERASE: lim = TMR_W'(RST_ERASE_CYC);
					CLS_PROG:  lim = TMR_W'(RST_PROG_CYC);
					CLS_READ:  lim = TMR_W'(RST_RD_CYC);
					default:   lim = need_fin ? TMR_W'(RST_PROG_CYC)
						: TMR_W'(RST_RDY_CYC);
				endcase
			end
			default: busy_start = 1'b0;
		endcase
	end

	assign ld_val = ld_fin ? TMR_W'(PROG_MAX_CYC)
		: ld_rst ? TMR_W'(RST_RDY_CYC) : lim;

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: if (ld_fin) next_state = S_FCMD;
				else if (take && !drop) next_state = S_CYC;
			S_CYC:  if (cyc_done) next_state = busy_start ? S_WB : S_IDLE;
			S_WB:   if (wbc == 3'h0) next_state = S_BUSY;
			S_BUSY: if (take) next_state = S_CYC;
				else if (rb_s || tmr == '0) next_state = S_IDLE;
			S_FCMD: if (cyc_done) next_state = S_FRD;
			S_FRD:  if (stat_rdy) next_state = S_FRST;
				else if (tmr == '0) next_state = S_IDLE;
			S_FRST: if (cyc_done) next_state = S_WB;
			default: next_state = S_IDLE;
		endcase
	end

	// reset enters the S_WB wait ahead of the ready wait, so the first strobe follows the write
	// protect release by at least the same 100 ns
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= S_WB;
			wbc <= 3'(WB_CYC - 1);
			tmr <= TMR_W'(RST_RDY_CYC);
		end else begin
			state <= next_state;
			if (ld_op || ld_rst) wbc <= 3'(WB_CYC - 1);
			else if (state == S_WB) wbc <= wbc - 3'h1;
			if (ld_fin || ld_op || ld_rst) tmr <= ld_val;
			else if ((state == S_BUSY || state == S_FRD) && tmr != '0)
				tmr <= tmr - TMR_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cur_kind <= K_CMD;
			cur_byte <= 8'h00;
			cyc_busy <= 1'b0;
		end else begin
			if (take) cur_kind <= nfc_kind_e'(req_kind_i);
			if (take) cur_byte <= req_byte_i;
			cyc_busy <= cyc_start || (cyc_busy && !cyc_done);
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			need_fin <= 1'b0;
			cls <= CLS_NONE;
		end else begin
			if (op_done && cur_cmd && cur_byte == CMD_CACHE_PROG)
				need_fin <= 1'b1;
			else if ((op_done && cur_cmd && cur_byte == CMD_PROG)
				|| ld_rst || tmo_fin
				|| (op_done && cur_cmd && cur_byte == CMD_RESET))
				need_fin <= 1'b0;
			if (ld_op) cls <= op_cls;
			else if (ld_rst || (state == S_BUSY && rb_s && !need_fin))
				cls <= CLS_NONE;
		end
	end

	// page address of the current command, compared at each confirm
	for (genvar g = 0; g < ROW_BYTES; g++) begin : g_row
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				row[g] <= 8'h00;
				last_row[g] <= 8'h00;
			end else begin
				if (take && req_kind_i == K_ADDR
					&& addr_idx == 3'(g + ROW_FIRST))
					row[g] <= req_byte_i;
				if (take && pconf && !same_row)
					last_row[g] <= row[g];
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr_idx <= 3'h0;
			pp_cnt <= 3'h0;
		end else begin
			if (take && is_cmd) addr_idx <= 3'h0;
			else if (take && req_kind_i == K_ADDR && addr_idx != 3'h7)
				addr_idx <= addr_idx + 3'h1;
			if (take && is_cmd && req_byte_i == CMD_ERASE_GO)
				pp_cnt <= 3'h0;
			else if (take && pconf && !pp_full)
				pp_cnt <= same_row ? pp_cnt + 3'h1 : 3'h1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rb_m <= 1'b0;
			rb_s <= 1'b0;
			fail_o <= 1'b0;
			pp_err_o <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_byte_o <= 8'h00;
			chip_sel_n_o <= 1'b1;
			write_prot_n_o <= 1'b0;
		end else begin
			rb_m <= ready_busy_out_i;
			rb_s <= rb_m;
			fail_o <= tmo_busy || tmo_fin;
			pp_err_o <= drop;
			rsp_valid_o <= op_done && cur_kind == K_RDATA;
			if (op_done && cur_kind == K_RDATA) rsp_byte_o <= cyc_rdata;
			chip_sel_n_o <= 1'b0;
			write_prot_n_o <= 1'b1;
		end
	end

	nfc_cycle u_cycle (
		.clk_i            (clk_i),
		.reset_n_i        (reset_n_i),
		.start_i          (cyc_start),
		.rd_i             (cyc_rd),
		.cmd_i            (cyc_cmd),
		.adr_i            (cyc_adr),
		.byte_i           (cyc_byte),
		.done_o           (cyc_done),
		.rdata_o          (cyc_rdata),
		.cmd_latch_o      (cmd_latch_o),
		.addr_latch_o     (addr_latch_o),
		.write_strobe_n_o (write_strobe_n_o),
		.read_strobe_n_o  (read_strobe_n_o),
		.dq_o             (dq_o),
		.dq_oe_o          (dq_oe_o),
		.dq_i             (dq_i)
	);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_fin_enter;
		state == S_IDLE ##1 state == S_FCMD;
	endsequence
	sequence s_stat_ready;
		state == S_FRD && stat_rdy;
	endsequence
	sequence s_cmd_strobe(logic [7:0] b);
		$rose(write_strobe_n_o) && cmd_latch_o && dq_o == b;
	endsequence

	AST_CMD_LATCH: assert property ($rose(write_strobe_n_o) && cmd_latch_o
		|-> !addr_latch_o && dq_oe_o)
		else $error("command strobe without a clean command latch");
	AST_ADDR_LATCH: assert property ($rose(write_strobe_n_o) && addr_latch_o
		|-> !cmd_latch_o && dq_oe_o)
		else $error("address strobe without a clean address latch");
	AST_WB_WAIT: assert property ($rose(state == S_WB) |-> (state == S_WB)[*5])
		else $error("ready wait started too early");
	AST_BUSY_CMD: assert property ($past(state) == S_BUSY && state == S_CYC
		|-> cur_byte == CMD_RESET)
		else $error("command other than reset cut into busy");
	AST_TIMEOUT: assert property (tmo_busy |=> fail_o && state == S_IDLE)
		else $error("busy timeout not reported");
	AST_PP_LIMIT: assert property (drop |=> pp_err_o && state == S_IDLE
		&& pp_cnt == PP_MAX)
		else $error("fifth partial program not refused");
	AST_FIN_STATUS: assert property (s_fin_enter
		|-> ##[1:8] s_cmd_strobe(CMD_STATUS))
		else $error("open cache program not followed by status read");
	AST_FIN_RESET: assert property (s_stat_ready
		|-> ##[1:8] s_cmd_strobe(CMD_RESET))
		else $error("reset missing after cache program completed");
	AST_LAST_PROG: assert property (op_done && cur_cmd && cur_byte == CMD_PROG
		&& need_fin |=> tmr == TMR_W'(2 * PROG_MAX_CYC))
		else $error("last cache page given too little time");
	AST_RST_ERASE: assert property (op_done && cur_cmd
		&& cur_byte == CMD_RESET && cls == CLS_ERASE
		|=> tmr == TMR_W'(RST_ERASE_CYC))
		else $error("reset during erase given wrong limit");
	AST_RD_FLOAT: assert property (!read_strobe_n_o |-> !dq_oe_o)
		else $error("host drives data while read strobe low");

endmodule
`default_nettype wire

//--- bench/nfc_flash_model.sv
/*
 * Behavioural flash device for the host controller bench.
 * Assumes the bench resolves the data pins and pulls ready/busy up.
 */
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model
	import nfc_pkg::*;
#(
	parameter int FAST_NS = 1000,
	parameter int SLOW_NS = 40000
)(
	input  wire logic       chip_sel_n_i,
	input  wire logic       cmd_latch_i,
	input  wire logic       addr_latch_i,
	input  wire logic       write_strobe_n_i,
	input  wire logic       read_strobe_n_i,
	input  wire logic [7:0] dq_i,
	input  wire logic       slow_i,
	output logic [7:0]      dq_o,
	output logic            dq_oe_o,
	output logic            ready_busy_out_o,
	output logic [23:0]     cmd_hist_o,
	output logic [39:0]     addr_hist_o,
	output logic [7:0]      misuse_o
);
	logic [7:0] data_ptr = 8'h00;
	logic       status_mode = 1'b0;
	int         busy_id = 0;

	initial begin
		dq_o = 8'h00;
		dq_oe_o = 1'b0;
		ready_busy_out_o = 1'b1;
		cmd_hist_o = 24'h00_0000;
		addr_hist_o = 40'h00_0000_0000;
		misuse_o = 8'h00;
	end

	// a newer busy period, such as a reset, cancels the older release
	task automatic go_busy(input int ns);
		int id;
		busy_id++;
		id = busy_id;
		#50 ready_busy_out_o = 1'b0;
		#(ns) if (id == busy_id) ready_busy_out_o = 1'b1;
	endtask

	always @(posedge write_strobe_n_i) begin
		if (!chip_sel_n_i && addr_latch_i)
			addr_hist_o = {addr_hist_o[31:0], dq_i};
		if (!chip_sel_n_i && cmd_latch_i) begin
			if (!ready_busy_out_o && dq_i != CMD_STATUS && dq_i != CMD_RESET)
				misuse_o = misuse_o + 8'h01;
			cmd_hist_o = {cmd_hist_o[15:0], dq_i};
			status_mode = (dq_i == CMD_STATUS || dq_i == CMD_STATUS_MP);
			if (dq_i == CMD_READ_GO)
				data_ptr = 8'h00;
			// every busy stays under its limit unless the bench slows it
			if (dq_i inside {CMD_READ_GO, CMD_CACHE_RD, CMD_CACHE_RD_LAST,
				CMD_COPY_RD, CMD_PROG, CMD_MP_CONF, CMD_CACHE_PROG,
				CMD_ERASE_GO, CMD_RESET}) begin
				fork
					go_busy((slow_i && dq_i != CMD_RESET) ? SLOW_NS : FAST_NS);
				join_none
			end
		end
	end

	always @(negedge read_strobe_n_i) begin
		if (!chip_sel_n_i) begin
			if (!ready_busy_out_o && !status_mode)
				misuse_o = misuse_o + 8'h01;
			#15;
			dq_oe_o = 1'b1;
			dq_o = status_mode ? {1'b1, ready_busy_out_o, 6'h00} : data_ptr;
			data_ptr = data_ptr + 8'h01;
		end
	end

	// released lines show the inverse so a stale byte cannot pass
	// a falling write strobe or a rising latch also ends a short-mode burst
	always @(posedge read_strobe_n_i or negedge write_strobe_n_i
		or posedge cmd_latch_i or posedge addr_latch_i) begin
		#25;
		dq_oe_o = 1'b0;
		dq_o = ~dq_o;
	end
endmodule
`default_nettype wire

//--- bench/nfc_host_test.sv
/*
 * Self-checking bench for the flash host controller.
 * Assumes the behavioural flash model stands on the pin side.
 */
`timescale 1ns/1ps
`default_nettype none
module nfc_host_test
	import nfc_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        req_valid_i = 1'b0;
	logic [1:0]  req_kind_i = 2'h0;
	logic [7:0]  req_byte_i = 8'h00;
	logic        slow = 1'b0;
	logic        req_ready_o, rsp_valid_o, ctl_busy_o, fail_o, pp_err_o;
	logic        cs_n, cle, ale, we_n, rd_n, wp_n, dq_oe_o, dev_oe, rb;
	logic [7:0]  rsp_byte_o, dq_o, dev_dq, misuse, b;
	logic [23:0] hist;
	logic [39:0] ahist;
	int          errors = 0;
	int          samples_checked = 0;
	int          fails = 0;
	int          pps = 0;
	wire logic [7:0] dq_bus = dq_oe_o ? dq_o : dev_dq;

	nfc_host #(.PROG_MAX_CYC(200), .ERASE_MAX_CYC(300), .RST_ERASE_CYC(100))
	i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
		.req_ready_o(req_ready_o), .req_kind_i(req_kind_i),
		.req_byte_i(req_byte_i), .rsp_valid_o(rsp_valid_o),
		.rsp_byte_o(rsp_byte_o), .ctl_busy_o(ctl_busy_o), .fail_o(fail_o),
		.pp_err_o(pp_err_o), .chip_sel_n_o(cs_n), .write_prot_n_o(wp_n),
		.cmd_latch_o(cle), .addr_latch_o(ale), .write_strobe_n_o(we_n),
		.read_strobe_n_o(rd_n), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
		.dq_i(dq_bus), .ready_busy_out_i(rb));

	nfc_flash_model i_flash (.chip_sel_n_i(cs_n), .cmd_latch_i(cle),
		.addr_latch_i(ale), .write_strobe_n_i(we_n), .read_strobe_n_i(rd_n),
		.dq_i(dq_o), .slow_i(slow), .dq_o(dev_dq), .dq_oe_o(dev_oe),
		.ready_busy_out_o(rb), .cmd_hist_o(hist), .addr_hist_o(ahist),
		.misuse_o(misuse));

	always #10 clk_i = ~clk_i;

	// pulses are counted mid-cycle, where they have settled
	always @(negedge clk_i) begin
		if (fail_o === 1'b1)
			fails++;
		if (pp_err_o === 1'b1)
			pps++;
		if (dq_oe_o === 1'b1)
			chk({7'h00, dev_oe}, 8'h00);
	end

	task automatic stop_test();
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request held until taken; a hold past the bound is a mismatch
	task automatic req(input logic [1:0] k, input logic [7:0] v);
		int n;
		n = 0;
		@(posedge clk_i);
		#2;
		req_valid_i = 1'b1;
		req_kind_i = k;
		req_byte_i = v;
		do begin
			@(negedge clk_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 3000);
		@(posedge clk_i);
		#2;
		req_valid_i = 1'b0;
		chk(8'(n < 3000), 8'h01);
	endtask

	task automatic idle();
		int n;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (ctl_busy_o !== 1'b0 && n < 3000);
		// let the mid-cycle pulse counters see the closing edge
		@(posedge clk_i);
		chk(8'(n < 3000), 8'h01);
	endtask

	task automatic rd(output logic [7:0] v);
		int n;
		n = 0;
		req(2'h3, 8'h00);
		do begin
			@(negedge clk_i);
			n++;
		end while (rsp_valid_o !== 1'b1 && n < 20);
		v = rsp_byte_o;
		chk(8'(n < 20), 8'h01);
	endtask

	task automatic addr5(input logic [7:0] base);
		for (int i = 0; i < 5; i++)
			req(2'h1, base + 8'(i));
	endtask

	task automatic t_status();
		req(2'h0, CMD_STATUS);
		rd(b);
		chk(hist[7:0], CMD_STATUS);
		chk({7'h00, b[STATUS_READY_BIT]}, 8'h01);
		chk({6'h00, wp_n, cs_n}, 8'h02);
	endtask

	task automatic t_page_read();
		req(2'h0, 8'h00);
		addr5(8'h20);
		req(2'h0, CMD_READ_GO);
		idle();
		for (int i = 0; i < 5; i++)
			chk(ahist[8*(4-i) +: 8], 8'h20 + 8'(i));
		rd(b);
		chk(b, 8'h00);
		rd(b);
		chk(b, 8'h01);
	endtask

	task automatic t_cache_busy();
		logic [7:0] c [4];
		int f;
		c = '{CMD_CACHE_RD, CMD_CACHE_RD_LAST, CMD_COPY_RD, CMD_MP_CONF};
		for (int i = 0; i < 4; i++) begin
			f = fails;
			req(2'h0, c[i]);
			idle();
			chk(8'(fails - f), 8'h00);
		end
	endtask

	task automatic t_timeout();
		int n;
		int f;
		n = 0;
		f = fails;
		slow = 1'b1;
		req(2'h0, 8'h00);
		addr5(8'h10);
		req(2'h0, CMD_READ_GO);
		do begin
			@(negedge clk_i);
			n++;
		end while (fails == f && n < 1500);
		chk(8'(n >= 1250 && n <= 1300), 8'h01);
		slow = 1'b0;
		req(2'h0, CMD_RESET);
		idle();
		chk(8'(fails - f), 8'h01);
	endtask

	task automatic page(input logic [7:0] base, input logic [7:0] c);
		req(2'h0, CMD_LOAD);
		addr5(base);
		req(2'h2, 8'h5A);
		req(2'h0, c);
		idle();
	endtask

	// the erase is cut short by a reset taken while busy
	task automatic t_partial();
		int p;
		int f;
		req(2'h0, 8'h60);
		addr5(8'h30);
		req(2'h0, CMD_ERASE_GO);
		f = fails;
		req(2'h0, CMD_RESET);
		idle();
		chk(8'(fails - f), 8'h00);
		p = pps;
		for (int i = 0; i < 5; i++) begin
			page(8'h40, CMD_PROG);
			chk(8'(pps - p), 8'(i == 4));
		end
		chk(hist[7:0], CMD_LOAD);
		req(2'h0, CMD_RESET);
		idle();
	endtask

	task automatic t_cache_close();
		page(8'h60, CMD_CACHE_PROG);
		page(8'h60, CMD_PROG);
		req(2'h0, 8'h00);
		idle();
		chk(hist[15:8], CMD_PROG);
		page(8'h60, CMD_CACHE_PROG);
		req(2'h0, 8'h00);
		idle();
		chk(hist[23:16], CMD_STATUS);
		chk(hist[15:8], CMD_RESET);
		chk(hist[7:0], 8'h00);
		chk(misuse, 8'h00);
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		#2;
		reset_n_i = 1'b1;
		t_status();
		t_page_read();
		t_cache_busy();
		t_timeout();
		t_partial();
		t_cache_close();
		stop_test();
	end

	// the whole sequence needs well under a quarter of this span
	initial begin
		#400000;
		errors++;
		stop_test();
	end
endmodule
`default_nettype wire
